// ==== core/timer8_compare.sv ====
/*
 * 8-bit timer/counter with one compare channel: APB register file, counter
 * in four waveform modes, compare output pin, overflow and compare flags.
 * Assumes an APB master on core_clk and an interrupt controller that pulses
 * the vector acknowledges; pin direction is kept outside this block.
 */
// Added by the designer: the APB slave port and the register addresses.
`default_nettype none
module timer8_compare (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic globalIrqEnable,
	input wire logic compareVectorAck,
	input wire logic overflowVectorAck,
	input wire logic externalCountPin,
	output logic compareOutputPin,
	output logic compareOutputOverride,
	output logic compareIrq,
	output logic overflowIrq
);
	import timer8_pkg::*;

	logic [7:0] ctrl_r, ctrl_nxt, cmp_r, cmp_nxt;
	logic [7:0] mask_r, mask_nxt, flag_r, flag_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic forceReq_r, forceReq_nxt;
	logic down_r, down_nxt, block_r, block_nxt;
	logic oc_r, oc_nxt, ovr_r, ovr_nxt;
	logic cmpIrq_r, cmpIrq_nxt, ovfIrq_r, ovfIrq_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	timer_cfg_t cfg;
	logic tick, setup, wrStrobe, cntWrite, flagWrite;
	logic hit, match, atTop, dirDown;
	logic ovfEvent, bottomEvent, topEvent;

	function automatic logic [7:0] step(input logic [7:0] v, input logic up);
		step = up ? v + 8'h01 : v - 8'h01;
	endfunction : step

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == CTRL_OFS || a == COUNT_OFS || a == CMP_OFS
			|| a == MASK_OFS || a == FLAG_OFS;
	endfunction : mapped

	// Waveform mode bits are split across the control byte
	assign cfg = '{
		wave: wave_mode_t'({ctrl_r[WAVE_HI_BIT], ctrl_r[WAVE_LO_BIT]}),
		com: com_t'(ctrl_r[COM_HI:COM_LO]),
		clkSrc: clk_src_t'(ctrl_r[CS_HI:0])
	};

	tick_source u_tick (
		.core_clk(core_clk),
		.rst(rst),
		.clkSrc(cfg.clkSrc),
		.externalCountPin(externalCountPin),
		.tick(tick)
	);

	assign setup = psel & ~penable;
	assign wrStrobe = psel & penable & pready_r & pwrite;
	assign cntWrite = wrStrobe & (paddr == COUNT_OFS);
	assign flagWrite = wrStrobe & (paddr == FLAG_OFS);

	// APB slave: answer always one access cycle after setup
	always_comb begin
		pready_nxt = setup;
		pslverr_nxt = 1'b0;
		prdata_nxt = prdata_r;
		if (setup) begin
			pslverr_nxt = ~mapped(paddr);
			prdata_nxt = 32'h0;
			if (!pwrite) begin
				unique case (paddr)
					CTRL_OFS: prdata_nxt = {24'h0, ctrl_r};
					COUNT_OFS: prdata_nxt = {24'h0, cnt_r};
					CMP_OFS: prdata_nxt = {24'h0, cmp_r};
					MASK_OFS: prdata_nxt = {24'h0, mask_r};
					FLAG_OFS: prdata_nxt = {24'h0, flag_r};
					default: prdata_nxt = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// Register file; force strobe acts a cycle later with the new mode bits
	always_comb begin
		ctrl_nxt = ctrl_r;
		cmp_nxt = cmp_r;
		mask_nxt = mask_r;
		forceReq_nxt = 1'b0;
		if (wrStrobe) begin
			unique case (paddr)
				CTRL_OFS: begin
					ctrl_nxt = {1'b0, pwdata[6:0]};
					forceReq_nxt = pwdata[FORCE_BIT] & ~pwdata[WAVE_LO_BIT];
				end
				CMP_OFS: cmp_nxt = pwdata[7:0];
				MASK_OFS: mask_nxt = {6'h0, pwdata[1:0]};
				default: ;
			endcase
		end
		// A new event beats a clear in the same cycle
		flag_nxt = 8'h0;
		flag_nxt[CMPA_BIT] = match | (flag_r[CMPA_BIT]
			& ~(flagWrite & pwdata[CMPA_BIT]) & ~compareVectorAck);
		flag_nxt[OVF_BIT] = ovfEvent | (flag_r[OVF_BIT]
			& ~(flagWrite & pwdata[OVF_BIT]) & ~overflowVectorAck);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r <= CTRL_RST;
			cmp_r <= CMP_RST;
			mask_r <= MASK_RST;
			flag_r <= FLAG_RST;
			forceReq_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			cmp_r <= cmp_nxt;
			mask_r <= mask_nxt;
			flag_r <= flag_nxt;
			forceReq_r <= forceReq_nxt;
		end
	end

	assign hit = cnt_r == cmp_r;
	assign match = tick & hit & ~block_r;
	assign atTop = cmp_r == MAX;
	// Bottom counts as upward so a zero compare keeps the pin low with COM_CLEAR, high with COM_SET
	assign dirDown = down_r & (cnt_r != BOTTOM);

	// Counter sequencing per waveform mode
	always_comb begin
		cnt_nxt = cnt_r;
		down_nxt = down_r;
		ovfEvent = 1'b0;
		bottomEvent = 1'b0;
		topEvent = 1'b0;
		block_nxt = block_r;
		if (cntWrite) begin
			cnt_nxt = pwdata[7:0];
			block_nxt = 1'b1;
		end else if (tick) begin
			block_nxt = 1'b0;
			unique case (cfg.wave)
				WAVE_PHASE: begin
					if (down_r && cnt_r == BOTTOM) begin
						down_nxt = 1'b0;
						cnt_nxt = step(cnt_r, 1'b1);
						ovfEvent = 1'b1;
					end else if (!down_r && cnt_r == MAX) begin
						down_nxt = 1'b1;
						cnt_nxt = step(cnt_r, 1'b0);
						topEvent = 1'b1;
					end else begin
						cnt_nxt = step(cnt_r, ~down_r);
					end
				end
				WAVE_CTC: begin
					down_nxt = 1'b0;
					cnt_nxt = hit ? BOTTOM : step(cnt_r, 1'b1);
					ovfEvent = cnt_r == MAX;
				end
				WAVE_NORMAL, WAVE_FAST: begin
					down_nxt = 1'b0;
					cnt_nxt = step(cnt_r, 1'b1);
					ovfEvent = cnt_r == MAX;
					bottomEvent = cnt_r == MAX;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt_r <= COUNT_RST;
			down_r <= 1'b0;
			block_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			down_r <= down_nxt;
			block_r <= block_nxt;
		end
	end

	// Compare output pin and interrupt lines
	always_comb begin
		oc_nxt = oc_r;
		ovr_nxt = cfg.com != COM_OFF;
		unique case (cfg.wave)
			WAVE_NORMAL, WAVE_CTC: begin
				if (match || forceReq_r) begin
					unique case (cfg.com)
						COM_OFF: oc_nxt = oc_r;
						COM_TOGGLE: oc_nxt = ~oc_r;
						COM_CLEAR: oc_nxt = 1'b0;
						COM_SET: oc_nxt = 1'b1;
					endcase
				end
			end
			WAVE_FAST: begin
				// Reserved 01 leaves the pin alone
				if (cfg.com[1]) begin
					if (match && !atTop) begin
						oc_nxt = cfg.com == COM_SET;
					end else if (bottomEvent) begin
						oc_nxt = cfg.com == COM_CLEAR;
					end
				end
			end
			WAVE_PHASE: begin
				if (cfg.com[1]) begin
					if (match && !atTop) begin
						oc_nxt = (cfg.com == COM_SET) ^ dirDown;
					end else if (topEvent && atTop) begin
						oc_nxt = cfg.com == COM_CLEAR;
					end
				end
			end
		endcase
		cmpIrq_nxt = globalIrqEnable & mask_nxt[CMPA_BIT] & flag_nxt[CMPA_BIT];
		ovfIrq_nxt = globalIrqEnable & mask_nxt[OVF_BIT] & flag_nxt[OVF_BIT];
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			oc_r <= 1'b0;
			ovr_r <= 1'b0;
			cmpIrq_r <= 1'b0;
			ovfIrq_r <= 1'b0;
		end else begin
			oc_r <= oc_nxt;
			ovr_r <= ovr_nxt;
			cmpIrq_r <= cmpIrq_nxt;
			ovfIrq_r <= ovfIrq_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign compareOutputPin = oc_r;
	assign compareOutputOverride = ovr_r;
	assign compareIrq = cmpIrq_r;
	assign overflowIrq = ovfIrq_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_ctrl_com_on;
		wrStrobe && paddr == CTRL_OFS && pwdata[COM_HI:COM_LO] != 2'b00;
	endsequence

	sequence s_phase_turn_up;
		cfg.wave == WAVE_PHASE && ovfEvent && cnt_r == BOTTOM && down_r;
	endsequence

	sequence s_fast_top_match;
		cfg.wave == WAVE_FAST && cfg.com == COM_CLEAR && atTop && match;
	endsequence

	a_override_follows_mode: assert property (
		s_ctrl_com_on |-> ##2 compareOutputOverride)
		else $error("override not raised after mode write");

	a_nonpwm_toggle: assert property (
		(cfg.wave inside {WAVE_NORMAL, WAVE_CTC}) && cfg.com == COM_TOGGLE
		&& match && !forceReq_r |=> compareOutputPin != $past(compareOutputPin))
		else $error("pin did not toggle on match");

	a_fast_bottom_set: assert property (
		cfg.wave == WAVE_FAST && cfg.com == COM_CLEAR && bottomEvent |=> compareOutputPin)
		else $error("fast pwm pin not set at bottom");

	a_fast_top_ignore: assert property (
		s_fast_top_match |=> compareOutputPin)
		else $error("fast pwm match at top not ignored");

	a_phase_up_clear: assert property (
		cfg.wave == WAVE_PHASE && cfg.com == COM_CLEAR && match
		&& !dirDown && !atTop |=> !compareOutputPin)
		else $error("phase pwm pin not cleared on up match");

	a_phase_top_set: assert property (
		cfg.wave == WAVE_PHASE && cfg.com == COM_CLEAR && atTop
		&& topEvent |=> compareOutputPin)
		else $error("phase pwm pin not set at top");

	a_stop_holds_count: assert property (
		cfg.clkSrc == CLK_STOP && !cntWrite |=> $stable(cnt_r))
		else $error("stopped counter moved");

	a_div1_increments: assert property (
		cfg.clkSrc == CLK_DIV1 && cfg.wave == WAVE_NORMAL && !cntWrite
		|=> cnt_r == $past(cnt_r) + 8'h01)
		else $error("undivided counter did not step");

	a_write_blocks_match: assert property (
		cntWrite |=> block_r ##0 (!match)[*1])
		else $error("match not blocked after counter write");

	a_flag_on_match: assert property (
		match |=> flag_r[CMPA_BIT])
		else $error("compare flag not set by match");

	a_cmp_irq_gated: assert property (
		compareIrq |-> mask_r[CMPA_BIT] && flag_r[CMPA_BIT] && $past(globalIrqEnable))
		else $error("compare interrupt without its enables");

	a_ovf_irq_gated: assert property (
		overflowIrq |-> mask_r[OVF_BIT] && flag_r[OVF_BIT] && $past(globalIrqEnable))
		else $error("overflow interrupt without its enables");

	a_phase_ovf_bottom: assert property (
		cfg.wave == WAVE_PHASE && ovfEvent |-> s_phase_turn_up ##1 flag_r[OVF_BIT])
		else $error("phase overflow not at bottom turn");

	a_phase_max_once: assert property (
		cfg.wave == WAVE_PHASE && tick && cnt_r == MAX && !down_r && !cntWrite
		|=> cnt_r == 8'hfe && down_r)
		else $error("phase counter did not leave max");

	a_unused_bits_zero: assert property (
		mask_r[7:2] == 6'h0 && flag_r[7:2] == 6'h0)
		else $error("unused mask or flag bits set");
endmodule : timer8_compare
`default_nettype wire

// ==== core/timer8_pkg.sv ====
/*
 * Shared constants, modes and carrier types of the 8-bit timer with one
 * compare channel. Assumes an APB slave with one aligned 32-bit word per register.
 */
`default_nettype none
package timer8_pkg;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] COUNT_OFS = 8'h04;
	localparam logic [7:0] CMP_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0c;
	localparam logic [7:0] FLAG_OFS = 8'h10;
	// Control register field positions
	localparam int FORCE_BIT = 7;
	localparam int WAVE_LO_BIT = 6;
	localparam int COM_HI = 5;
	localparam int COM_LO = 4;
	localparam int WAVE_HI_BIT = 3;
	localparam int CS_HI = 2;
	// Mask and flag bit positions
	localparam int CMPA_BIT = 1;
	localparam int OVF_BIT = 0;
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] FLAG_RST = 8'h00;
	// Counter end points
	localparam logic [7:0] BOTTOM = 8'h00;
	localparam logic [7:0] MAX = 8'hff;
	// Prescaler taps as powers of two
	localparam int PRESCALE_W = 10;
	localparam int DIV8_BITS = 3;
	localparam int DIV64_BITS = 6;
	localparam int DIV256_BITS = 8;
	localparam int DIV1024_BITS = 10;

	typedef enum logic [1:0] {WAVE_NORMAL, WAVE_PHASE, WAVE_CTC, WAVE_FAST} wave_mode_t;
	typedef enum logic [1:0] {COM_OFF, COM_TOGGLE, COM_CLEAR, COM_SET} com_t;
	typedef enum logic [2:0] {
		CLK_STOP, CLK_DIV1, CLK_DIV8, CLK_DIV64,
		CLK_DIV256, CLK_DIV1024, CLK_EXT_FALL, CLK_EXT_RISE
	} clk_src_t;

	typedef struct packed {
		wave_mode_t wave;
		com_t com;
		clk_src_t clkSrc;
	} timer_cfg_t;
endpackage : timer8_pkg
`default_nettype wire

// ==== core/tick_source.sv ====
/*
 * Timer tick source: free-running prescaler, count pin synchroniser and
 * edge detector, and the clock source selector.
 * Assumes the count pin is asynchronous to core_clk.
 */
`default_nettype none
module tick_source (
	input wire logic core_clk,
	input wire logic rst,
	input wire timer8_pkg::clk_src_t clkSrc,
	input wire logic externalCountPin,
	output logic tick
);
	import timer8_pkg::*;

	logic [PRESCALE_W-1:0] pre_r, pre_nxt;
	logic syncA_r, syncB_r, last_r;
	logic rising, falling;

	function automatic logic tapHit(input logic [PRESCALE_W-1:0] p, input int bits);
		logic [PRESCALE_W-1:0] m;
		m = PRESCALE_W'((32'd1 << bits) - 32'd1);
		tapHit = (p & m) == m;
	endfunction : tapHit

	always_comb begin
		pre_nxt = pre_r + PRESCALE_W'(1);
		rising = syncB_r & ~last_r;
		falling = ~syncB_r & last_r;
		unique case (clkSrc)
			CLK_STOP: tick = 1'b0;
			CLK_DIV1: tick = 1'b1;
			CLK_DIV8: tick = tapHit(pre_r, DIV8_BITS);
			CLK_DIV64: tick = tapHit(pre_r, DIV64_BITS);
			CLK_DIV256: tick = tapHit(pre_r, DIV256_BITS);
			CLK_DIV1024: tick = tapHit(pre_r, DIV1024_BITS);
			CLK_EXT_FALL: tick = falling;
			CLK_EXT_RISE: tick = rising;
		endcase
	end

	// Pin is sampled whatever its port direction, so software can clock it
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pre_r <= '0;
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			pre_r <= pre_nxt;
			syncA_r <= externalCountPin;
			syncB_r <= syncA_r;
			last_r <= syncB_r;
		end
	end
endmodule : tick_source
`default_nettype wire

// ==== bench/pin_partner.sv ====
/*
 * Far side of the timer: a count pin source toggling at a chosen half period,
 * and the port pad that shows the compare output only while it overrides.
 * Assumes core_clk and rst of the bench; go and halfPer come from the bench.
 */
`default_nettype none
module pin_partner (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic go,
	input wire logic [3:0] halfPer,
	input wire logic compareOutputPin,
	input wire logic compareOutputOverride,
	output logic externalCountPin,
	output logic [7:0] toggles,
	output logic [7:0] rises,
	output logic portLevel
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	// Pull-up holds the pad high while the port function owns it
	// Direction bit taken as output: the pad shows the wave while overridden
	assign portLevel = compareOutputOverride ? compareOutputPin : 1'b1;
	// Half periods of two clocks or more, so every level is sampled
	always @(posedge core_clk) begin
		if (rst) begin
			externalCountPin <= 1'b0;
			cnt <= 4'h0;
			toggles <= 8'h00;
			rises <= 8'h00;
		end else if (go && cnt >= halfPer) begin
			cnt <= 4'h1;
			externalCountPin <= !externalCountPin;
			toggles <= toggles + 8'h01;
			rises <= rises + {7'h00, !externalCountPin};
		end else if (go) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : pin_partner
`default_nettype wire

// ==== bench/testbench.sv ====
/*
 * Self-checking bench of the 8-bit timer: APB master tasks, random and corner scenarios.
 * Assumes timer8_pkg, timer8_compare and pin_partner are compiled before it.
 */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import timer8_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic globalIrqEnable = 1'b0, compareVectorAck = 1'b0, overflowVectorAck = 1'b0, go = 1'b0;
	logic [3:0] halfPer = 4'h2;
	logic pready, pslverr, externalCountPin, compareOutputPin, compareOutputOverride;
	logic compareIrq, overflowIrq, portLevel, err;
	logic [7:0] toggles, rises, q, c, cmp, r0, togStart, riseStart;
	int errors = 0, n_compared = 0, seed = 83;
	int sh[4] = '{DIV8_BITS, DIV64_BITS, DIV256_BITS, DIV1024_BITS};

	always #50 core_clk = ~core_clk;

	timer8_compare dut_u (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.globalIrqEnable(globalIrqEnable), .compareVectorAck(compareVectorAck),
		.overflowVectorAck(overflowVectorAck), .externalCountPin(externalCountPin),
		.compareOutputPin(compareOutputPin), .compareOutputOverride(compareOutputOverride),
		.compareIrq(compareIrq), .overflowIrq(overflowIrq));
	pin_partner partner_u (.core_clk(core_clk), .rst(rst), .go(go), .halfPer(halfPer),
		.compareOutputPin(compareOutputPin), .compareOutputOverride(compareOutputOverride),
		.externalCountPin(externalCountPin), .toggles(toggles), .rises(rises), .portLevel(portLevel));

	task stop_test;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until pready is sampled high; only the watchdog bounds the wait
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		chk(pready, 1'b1);
		chk(n, 1);
		q = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(q, exp);
	endtask : rdchk

	function logic [7:0] ctl(input wave_mode_t w, input com_t m, input clk_src_t s);
		return {1'b0, w[0], m, w[1], s};
	endfunction : ctl

	// Runs for a while, then stops the clock keeping the mode
	task run(input logic [7:0] cb, input int cycles);
		apb(1'b1, CTRL_OFS, cb);
		repeat (cycles) @(posedge core_clk);
		apb(1'b1, CTRL_OFS, cb & 8'hf8);
	endtask : run

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		for (int k = 0; k < 5; k++) rdchk(8'(k * 4), 8'h00);
		apb(1'b0, 8'h14, 8'h00);
		chk({err, q}, 9'h100);
		c = 8'($random(seed));
		apb(1'b1, COUNT_OFS, c);
		rdchk(COUNT_OFS, c);
		cmp = 8'($random(seed));
		apb(1'b1, CMP_OFS, cmp);
		rdchk(CMP_OFS, cmp);
		apb(1'b1, MASK_OFS, 8'hff);
		rdchk(MASK_OFS, 8'h03);
		apb(1'b1, FLAG_OFS, 8'hff);
		rdchk(FLAG_OFS, 8'h00);
		globalIrqEnable <= 1'b1;
		// Toggle, clear, set from a pin that starts low: 1, 0, 1
		for (int k = 1; k < 4; k++) begin
			cmp = 8'h10 + 8'($random(seed) & 32'h7f);
			apb(1'b1, CMP_OFS, cmp);
			apb(1'b1, COUNT_OFS, cmp - 8'h05);
			run(ctl(WAVE_NORMAL, com_t'(k), CLK_DIV1), 20);
			chk(compareOutputPin, k != 2);
			chk(compareOutputOverride, 1'b1);
			chk(portLevel, k != 2);
			chk(compareIrq, 1'b1);
			globalIrqEnable <= 1'b0;
			repeat (2) @(posedge core_clk);
			chk(compareIrq, 1'b0);
			globalIrqEnable <= 1'b1;
			rdchk(FLAG_OFS, 8'h02);
			apb(1'b1, FLAG_OFS, 8'h02);
			rdchk(FLAG_OFS, 8'h00);
		end
		apb(1'b1, CTRL_OFS, 8'h00);
		repeat (2) @(posedge core_clk);
		chk({compareOutputOverride, portLevel}, 2'b01);
		apb(1'b1, COUNT_OFS, 8'hfa);
		run(ctl(WAVE_NORMAL, COM_OFF, CLK_DIV1), 15);
		rdchk(FLAG_OFS, 8'h01);
		chk(overflowIrq, 1'b1);
		@(posedge core_clk) overflowVectorAck <= 1'b1;
		@(posedge core_clk) overflowVectorAck <= 1'b0;
		rdchk(FLAG_OFS, 8'h00);
		chk(overflowIrq, 1'b0);
		// A counter write while running hides the match on the next tick
		apb(1'b1, CMP_OFS, 8'h40);
		apb(1'b1, CTRL_OFS, ctl(WAVE_NORMAL, COM_TOGGLE, CLK_DIV1));
		apb(1'b1, COUNT_OFS, 8'h40);
		run(ctl(WAVE_NORMAL, COM_TOGGLE, CLK_DIV1), 8);
		rdchk(FLAG_OFS, 8'h00);
		chk(compareOutputPin, 1'b1);
		// Force strobe acts with the stored mode bits, one cycle after the write
		apb(1'b1, CTRL_OFS, 8'h80 | ctl(WAVE_NORMAL, COM_TOGGLE, CLK_STOP));
		repeat (2) @(posedge core_clk);
		chk(compareOutputPin, 1'b0);
		rdchk(FLAG_OFS, 8'h00);
		apb(1'b1, COUNT_OFS, 8'h33);
		repeat (50) @(posedge core_clk);
		rdchk(COUNT_OFS, 8'h33);
		for (int k = 2; k < 6; k++) begin
			apb(1'b1, CTRL_OFS, ctl(WAVE_NORMAL, COM_OFF, clk_src_t'(k)));
			apb(1'b0, COUNT_OFS, 8'h00);
			r0 = q;
			repeat ((1 << sh[k - 2]) * 3) @(posedge core_clk);
			apb(1'b0, COUNT_OFS, 8'h00);
			chk((q - r0 == 8'h03) || (q - r0 == 8'h04), 1'b1);
		end
		for (int k = 6; k < 8; k++) begin
			apb(1'b1, CTRL_OFS, ctl(WAVE_NORMAL, COM_OFF, clk_src_t'(k)));
			apb(1'b0, COUNT_OFS, 8'h00);
			r0 = q;
			togStart = toggles;
			riseStart = rises;
			halfPer <= 4'h2 + 4'($random(seed) & 32'h7);
			go <= 1'b1;
			repeat (40 + ($random(seed) & 32'h3f)) @(posedge core_clk);
			go <= 1'b0;
			repeat (6) @(posedge core_clk);
			apb(1'b0, COUNT_OFS, 8'h00);
			chk(8'(q - r0), 8'((k == 7) ? rises - riseStart : (toggles - togStart) - (rises - riseStart)));
		end
		apb(1'b1, FLAG_OFS, 8'h03);
		apb(1'b1, COUNT_OFS, 8'hf0);
		run(ctl(WAVE_PHASE, COM_CLEAR, CLK_DIV1), 30);
		rdchk(FLAG_OFS, 8'h00);
		run(ctl(WAVE_PHASE, COM_CLEAR, CLK_DIV1), 300);
		apb(1'b0, FLAG_OFS, 8'h00);
		chk(q[0], 1'b1);
		// Set on the way down at 0x40, cleared again on the way up past it
		chk(compareOutputPin, 1'b0);
		apb(1'b1, CMP_OFS, 8'h20);
		apb(1'b1, COUNT_OFS, 8'h00);
		apb(1'b1, FLAG_OFS, 8'h03);
		run(ctl(WAVE_CTC, COM_OFF, CLK_DIV1), 100);
		apb(1'b0, COUNT_OFS, 8'h00);
		chk(q <= 8'h20, 1'b1);
		rdchk(FLAG_OFS, 8'h02);
		chk(compareIrq, 1'b1);
		@(posedge core_clk) compareVectorAck <= 1'b1;
		@(posedge core_clk) compareVectorAck <= 1'b0;
		rdchk(FLAG_OFS, 8'h00);
		chk(compareIrq, 1'b0);
		// Pin high from bottom up to the match, low after it; inverted in mode 11
		// Last two runs are phase correct with compare at top: level fixed at top
		for (int k = 0; k < 8; k++) begin
			cmp = (k < 2 || k > 5) ? 8'hff : (k < 4) ? 8'h80 : 8'($random(seed)) | 8'h01;
			apb(1'b1, CMP_OFS, cmp);
			run(ctl((k > 5) ? WAVE_PHASE : WAVE_FAST, com_t'(2 + k % 2), CLK_DIV1),
				300 + ($random(seed) & 32'hff) + ((k > 5) ? 300 : 0));
			apb(1'b0, COUNT_OFS, 8'h00);
			c = q;
			if (c != 8'h00)
				chk(compareOutputPin, (c <= cmp) ^ (k % 2));
		end
		stop_test;
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		errors++;
		stop_test;
	end
endmodule : testbench
`default_nettype wire
